/* File: hw/slot_capability_register.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - bit 0 reads one when an attention button exists
// - bit 1 reads one when a slot power controller exists
// - bit 2 reads one when a retention latch sensor exists
// - bit 3 reads one when an attention indicator exists
// - bit 4 reads one when a power indicator exists
// - bit 5 one means the adapter may be pulled without notice
// - bit 6 one means the slot supports hot-plug
// - bits 14:7 hold the writable eight-bit power limit value
// - bits 16:15 hold the limit scale, codes 0..3 for 1.0 to 0.001
// - limit message sent on capability write with a slot present and on link entering up
// - bit 17 reads one when an electromechanical interlock exists
// - bit 18 always reads zero
// - bits 31:19 hold the physical slot number, zero for board devices
// - with no slot implemented, all fields read zero and are read-only
module slot_capability_register
  import slot_cap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // port configuration
  input wire logic slot_implemented,
  // link state
  input wire logic link_dl_up,
  // power limit message toward the slot
  output logic limit_msg_valid,
  output logic [7:0] limit_msg_value,
  output logic [1:0] limit_msg_scale
);
  import slot_cap_pkg::*;

  logic [PRESENCE_W-1:0] presence_q;
  logic [SLOT_NUM_W-1:0] slot_num_q;
  logic [LIMIT_VALUE_W+LIMIT_SCALE_W-1:0] limit_q;
  logic limit_wr;
  logic link_up_q;
  logic send_pend_q;
  logic [15:0] msg_count_q;
  logic [31:0] cap_view;
  logic [31:0] rdata_q;
  logic msg_valid_q;
  logic [7:0] msg_value_q;
  logic [1:0] msg_scale_q;

  // writes to the capability word, gated by slot presence
  function automatic logic cap_hit(input logic [11:0] a);
    return a == SLOT_CAP_OFFSET;
  endfunction : cap_hit

  assign limit_wr = reg_wr && cap_hit(reg_addr) && slot_implemented;

  // presence and slot number are locked fields, writable only with a slot
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      presence_q <= '0;
      slot_num_q <= '0;
    end else if (limit_wr) begin
      presence_q <= {reg_wdata[INTERLOCK_BIT], reg_wdata[HOTPLUG_BIT:ATTN_BUTTON_BIT]};
      slot_num_q <= reg_wdata[SLOT_NUM_LSB +: SLOT_NUM_W];
    end
  end

  // limit value and scale storage
  slot_limit_hold #(
    .W(LIMIT_VALUE_W + LIMIT_SCALE_W)
  ) u_limit (
    .sys_clk(sys_clk),
    .srst(srst),
    .wr_en(limit_wr),
    .wr_data(reg_wdata[LIMIT_VALUE_LSB +: LIMIT_VALUE_W + LIMIT_SCALE_W]),
    .rd_data(limit_q)
  );

  // visible register image; everything but bit 18 masked without a slot
  always_comb begin
    cap_view = '0;
    if (slot_implemented) begin
      cap_view[ATTN_BUTTON_BIT] = presence_q[0];
      cap_view[POWER_CTRL_BIT] = presence_q[1];
      cap_view[RETENTION_BIT] = presence_q[2];
      cap_view[ATTN_IND_BIT] = presence_q[3];
      cap_view[POWER_IND_BIT] = presence_q[4];
      cap_view[SURPRISE_BIT] = presence_q[5];
      cap_view[HOTPLUG_BIT] = presence_q[6];
      cap_view[LIMIT_VALUE_LSB +: LIMIT_VALUE_W + LIMIT_SCALE_W] = limit_q;
      cap_view[INTERLOCK_BIT] = presence_q[7];
      cap_view[SLOT_NUM_LSB +: SLOT_NUM_W] = slot_num_q;
    end
    cap_view[NO_CMD_DONE_BIT] = 1'b0;
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SLOT_CAP_OFFSET: rdata_q <= cap_view;
        SLOT_CFG_OFFSET: rdata_q <= {31'h0000_0000, link_up_q};
        SLOT_MSG_OFFSET: rdata_q <= {16'h0000, msg_count_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // link state edge; link_up_q is link_dl_up delayed one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link_up_q <= 1'b0;
    end else begin
      link_up_q <= link_dl_up;
    end
  end

  // message request waits one cycle so it carries freshly written limits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      send_pend_q <= 1'b0;
    end else begin
      send_pend_q <= limit_wr || (link_dl_up && !link_up_q);
    end
  end

  // message outputs, one-cycle pulse with current value and scale, or zero and SCALE_X1 without a slot
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      msg_valid_q <= 1'b0;
      msg_value_q <= '0;
      msg_scale_q <= '0;
    end else begin
      msg_valid_q <= send_pend_q;
      if (send_pend_q) begin
        msg_value_q <= slot_implemented ? limit_q[LIMIT_VALUE_W-1:0] : 8'h00;
        msg_scale_q <= slot_implemented ? limit_q[LIMIT_VALUE_W +: LIMIT_SCALE_W] : SCALE_X1;
      end
    end
  end

  // count of messages sent, wraps, for software diagnosis
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      msg_count_q <= '0;
    end else if (send_pend_q) begin
      msg_count_q <= msg_count_q + 16'h0001;
    end
  end

  assign reg_rdata = rdata_q;
  assign limit_msg_valid = msg_valid_q;
  assign limit_msg_value = msg_value_q;
  assign limit_msg_scale = msg_scale_q;

  AST_NO_CMD_DONE_SUPPORT_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
    $past(reg_rd) |-> !reg_rdata[NO_CMD_DONE_BIT]) else $error("bit 18 read nonzero");
  AST_NOSLOT_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
    ($past(reg_rd) && $past(reg_addr) == SLOT_CAP_OFFSET && !$past(slot_implemented)) |-> reg_rdata == 32'h0)
    else $error("capability not zero without slot");
  AST_WRITE_MSG: assert property (@(posedge sys_clk) disable iff (srst)
    limit_wr |-> ##2 limit_msg_valid) else $error("write gave no message");
  AST_LINKUP_MSG: assert property (@(posedge sys_clk) disable iff (srst)
    (link_dl_up && !link_up_q) |-> ##2 limit_msg_valid) else $error("link up gave no message");
  AST_MSG_VALUE: assert property (@(posedge sys_clk) disable iff (srst)
    (limit_wr && slot_implemented ##1 slot_implemented) |-> ##1
    limit_msg_value == $past(reg_wdata[14:7], 2)) else $error("message value wrong");
  AST_MSG_SCALE: assert property (@(posedge sys_clk) disable iff (srst)
    (limit_wr ##1 slot_implemented) |-> ##1
    limit_msg_scale == $past(reg_wdata[16:15], 2)) else $error("message scale wrong");
  AST_NO_SPURIOUS: assert property (@(posedge sys_clk) disable iff (srst)
    limit_msg_valid |-> $past(limit_wr, 2) || ($past(link_dl_up, 2) && !$past(link_up_q, 2)))
    else $error("message without cause");
  AST_READBACK: assert property (@(posedge sys_clk) disable iff (srst)
    (limit_wr ##1 (reg_rd && reg_addr == SLOT_CAP_OFFSET && slot_implemented && !reg_wr)) |-> ##1
    reg_rdata[31:19] == $past(reg_wdata[31:19], 2) && reg_rdata[6:0] == $past(reg_wdata[6:0], 2)
    && reg_rdata[17] == $past(reg_wdata[17], 2)) else $error("readback mismatch");
  // without a slot every stored field must stay frozen, whatever software writes
  AST_NOSLOT_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
    !slot_implemented |=> $stable(limit_q) && $stable(presence_q) && $stable(slot_num_q))
    else $error("field changed without slot");
  // a message launched without a slot carries no stale limit
  AST_NOSLOT_MSG: assert property (@(posedge sys_clk) disable iff (srst)
    ($past(send_pend_q) && !$past(slot_implemented)) |-> limit_msg_value == 8'h00 && limit_msg_scale == SCALE_X1)
    else $error("message carried limit without slot");
endmodule : slot_capability_register

/* File: hw/slot_cap_pkg.sv */
package slot_cap_pkg;
  // register map
  localparam logic [11:0] SLOT_CAP_OFFSET = 12'h054;
  localparam logic [11:0] SLOT_CFG_OFFSET = 12'h100;
  localparam logic [11:0] SLOT_MSG_OFFSET = 12'h104;
  localparam logic [31:0] SLOT_CAP_RESET = 32'h0000_0000;
  // field positions in slot_capabilities
  localparam int ATTN_BUTTON_BIT = 0;
  localparam int POWER_CTRL_BIT = 1;
  localparam int RETENTION_BIT = 2;
  localparam int ATTN_IND_BIT = 3;
  localparam int POWER_IND_BIT = 4;
  localparam int SURPRISE_BIT = 5;
  localparam int HOTPLUG_BIT = 6;
  localparam int LIMIT_VALUE_LSB = 7;
  localparam int LIMIT_VALUE_W = 8;
  localparam int LIMIT_SCALE_LSB = 15;
  localparam int LIMIT_SCALE_W = 2;
  localparam int INTERLOCK_BIT = 17;
  localparam int NO_CMD_DONE_BIT = 18;
  localparam int SLOT_NUM_LSB = 19;
  localparam int SLOT_NUM_W = 13;
  // bits of the writable presence mask (low 7 plus interlock)
  localparam int PRESENCE_W = 8;
  // power limit scale codes
  localparam logic [1:0] SCALE_X1 = 2'h0;
  localparam logic [1:0] SCALE_XP1 = 2'h1;
  localparam logic [1:0] SCALE_XP01 = 2'h2;
  localparam logic [1:0] SCALE_XP001 = 2'h3;
endpackage : slot_cap_pkg

/* File: hw/slot_limit_hold.sv */
`timescale 1ns/10ps
// power limit value and scale storage, read data out of a register
module slot_limit_hold #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // write side
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // held value
  output logic [W-1:0] rd_data
);
  // writes land one cycle later, as the message sender expects
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= '0;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule : slot_limit_hold

/* File: tb/slot_msg_sink.sv */
`timescale 1ns/10ps
// device in the slot: keeps the latest power limit it was sent
module slot_msg_sink (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // message from the port
  input wire logic msg_valid,
  input wire logic [7:0] msg_value,
  input wire logic [1:0] msg_scale,
  // what the device has taken
  output logic [31:0] got_count_q,
  output logic [9:0] got_limit_q
);
  // only the newest limit matters to a device, so older ones are dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      got_count_q <= 32'h0;
      got_limit_q <= 10'h0;
    end else if (msg_valid) begin
      got_count_q <= got_count_q + 32'h1;
      got_limit_q <= {msg_scale, msg_value};
    end
  end
endmodule : slot_msg_sink

/* File: tb/slot_capability_register_bench.sv */
`timescale 1ns/10ps
module slot_capability_register_bench;
  import slot_cap_pkg::*;
  logic sys_clk, srst, reg_wr, reg_rd, slot_implemented, link_dl_up, limit_msg_valid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, got_count_q, d, n;
  logic [9:0] got_limit_q;
  logic [7:0] limit_msg_value;
  logic [1:0] limit_msg_scale;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  slot_capability_register u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_implemented(slot_implemented),
    .link_dl_up(link_dl_up), .limit_msg_valid(limit_msg_valid), .limit_msg_value(limit_msg_value),
    .limit_msg_scale(limit_msg_scale));
  slot_msg_sink u_sink (.sys_clk(sys_clk), .srst(srst), .msg_valid(limit_msg_valid), .msg_value(limit_msg_value),
    .msg_scale(limit_msg_scale), .got_count_q(got_count_q), .got_limit_q(got_limit_q));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // slot present: every written bit reads back except the hardwired one
  function automatic logic [31:0] cap_of(input logic [31:0] w);
    cap_of = w & ~(32'h1 << NO_CMD_DONE_BIT);
  endfunction : cap_of

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check(what, exp, reg_rdata);
  endtask : rd

  // write then read back with no idle cycle between, as the bus allows
  task automatic wr_rd(input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= SLOT_CAP_OFFSET;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("cap", cap_of(v), reg_rdata);
  endtask : wr_rd

  // message lands two cycles after its cause; wait one spare
  task automatic msg(input logic [31:0] cnt, input logic [9:0] lim);
    repeat (3) @(posedge sys_clk);
    #1 check("msg count", cnt, got_count_q);
    check("msg limit", {22'h0, lim}, got_limit_q);
  endtask : msg

  // hang guard, run needs well under this
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    srst = 1'b1;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slot_implemented = 1'b1;
    link_dl_up = 1'b0;
    void'($urandom(32'hFFC4B853));
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rd(SLOT_CAP_OFFSET, 32'h0, "cap reset");
    // all scale codes first, then an all-ones corner, then random words
    for (int i = 0; i < 24; i++) begin
      d = $urandom();
      if (i < 4) d[16:15] = i[1:0];
      if (i == 4) d = 32'hFFFFFFFF;
      n = got_count_q;
      wr_rd(d);
      msg(n + 32'h1, {d[16:15], d[14:7]});
    end
    // one message for each of the 24 accepted writes
    rd(SLOT_MSG_OFFSET, 32'h0000_0018, "msg total");
    n = got_count_q;
    wr(12'h200, $urandom());
    msg(n, {d[16:15], d[14:7]});
    rd(12'h200, 32'h0, "unmapped");
    rd(SLOT_CAP_OFFSET, cap_of(d), "cap kept");
    @(posedge sys_clk);
    link_dl_up <= 1'b1;
    msg(n + 32'h1, {d[16:15], d[14:7]});
    rd(SLOT_CFG_OFFSET, 32'h0000_0001, "link seen");
    @(posedge sys_clk);
    link_dl_up <= 1'b0;
    slot_implemented <= 1'b0;
    rd(SLOT_CAP_OFFSET, 32'h0, "cap no slot");
    wr(SLOT_CAP_OFFSET, 32'hFFFFFFFF);
    msg(n + 32'h1, {d[16:15], d[14:7]});
    rd(SLOT_CAP_OFFSET, 32'h0, "cap no slot wr");
    @(posedge sys_clk);
    link_dl_up <= 1'b1;
    msg(n + 32'h2, 10'h0);
    // reset in mid-run with a slot present again
    @(posedge sys_clk);
    srst <= 1'b1;
    slot_implemented <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    rd(SLOT_CAP_OFFSET, 32'h0, "cap rereset");
    // link stayed up across reset, so the first cycle after it is a fresh rise
    msg(32'h1, 10'h0);
    final_report();
  end
endmodule : slot_capability_register_bench
